// *** rmfc_device.sv ***
// Sensor end: run-time register bank, frame checksum check and SENT checksum
// Operation
// RULE_01: Two-bit readout selection, word 9, resets zero
// RULE_02: Selection picks amplitude pair for words 2, 3
// RULE_03: Host trusts amplitudes only in valid modes
// RULE_04: Gain freeze bit gates gain field writes
// RULE_05: Converter offset writable only under gain freeze
// RULE_06: Oscillator freeze gates drive current writes
// RULE_07: Word 6 reports twelve-bit temperature code
// RULE_08: Words 0 to 8 are read-only results
// RULE_09: Word 12 bit 15 shows verify status
// RULE_10: Redundant pair uses different diagnostic periods; this bank has no diagnostic period logic
// RULE_11: Frame checksum in low byte, upper 24 bits
// RULE_12: Checksum polynomial 0x107, seed all ones
// RULE_13: SENT nibble CRC polynomial 0x1D, seed 5
// RULE_14: SENT CRC over six data nibbles only
// RULE_15: Blocked or read-only writes change nothing
// RULE_16: Unassigned bits read zero, ignore writes
`timescale 1ns/1ns
`include "rmfc_map.svh"
module rmfc_device
    import rmfc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Link
    rmfc_link_if.device link,
    // Measurement results
    input wire logic [15:0] positionResult,
    input wire logic [15:0] receiverVectorAmplitude,
    input wire logic [15:0] receiverPair32Amplitude,
    input wire logic [15:0] receiverPair21Amplitude,
    input wire logic [15:0] receiverPair13Amplitude,
    input wire logic [13:0] excitationAmplitude,
    input wire logic [2:0] excitationScale,
    input wire logic [11:0] dieTemperature,
    input wire logic [10:0] outputAmplitude,
    input wire logic [15:0] faultWord,
    input wire logic nvmVerifyStatus,
    input wire logic [7:0] watchdogCount,
    // Loop overrides
    output logic [1:0] readoutSelect,
    output logic gainFreeze,
    output logic oscFreeze,
    output logic [4:0] gainOverride,
    output logic [6:0] offsetOverride,
    output logic [7:0] driveOverride,
    // SENT checksum
    input wire logic sentCalc,
    input wire logic [23:0] sentNibbles,
    output logic [3:0] sentCrc,
    output logic sentCrcValid
);

    rmfc_dev_state_t s_reg;
    rmfc_dev_state_t s_next;

    always_comb begin
        logic [5:0] addr;
        logic wr;
        rmfc_word_t wdata;
        rmfc_word_t rd;
        logic crcOk;
        addr = link.reqFrame[`RMFC_FRM_ADDR_HI:`RMFC_FRM_ADDR_LO];
        wr = link.reqFrame[`RMFC_FRM_WR];
        wdata = link.reqFrame[`RMFC_FRM_DATA_HI:`RMFC_FRM_DATA_LO];
        // RULE_11: Check received checksum
        // RULE_12: Same seed and polynomial
        crcOk = (rmfc_crc8(link.reqFrame[`RMFC_FRM_WR:`RMFC_FRM_BODY_LO])
                 == link.reqFrame[`RMFC_FRM_CRC_HI:`RMFC_FRM_CRC_LO]);
        s_next = s_reg;
        s_next.rspValid = 1'b0;
        s_next.sentValid = 1'b0;

        // RULE_16: Unassigned bits zero
        rd = `RMFC_WORD_ZERO;
        case (addr)
            // RULE_08: Read-only result words
            `RMFC_ADDR_POSITION: begin
                rd = positionResult;
            end
            `RMFC_ADDR_VREC: begin
                rd = receiverVectorAmplitude;
            end
            // RULE_02: Amplitude pair select
            `RMFC_ADDR_AMP_A: begin
                if (s_reg.sel == `RMFC_SEL_PAIR_13) begin
                    rd = receiverPair21Amplitude;
                end else begin
                    rd = receiverPair32Amplitude;
                end
            end
            `RMFC_ADDR_AMP_B: begin
                if (s_reg.sel == `RMFC_SEL_PAIR_13) begin
                    rd = receiverPair13Amplitude;
                end else begin
                    rd = receiverPair21Amplitude;
                end
            end
            // Narrow results are zero-extended into the word
            `RMFC_ADDR_EXC_AMP: begin
                rd[`RMFC_EXC_AMP_HI:`RMFC_FIELD_LO] = excitationAmplitude;
            end
            `RMFC_ADDR_EXC_SCALE: begin
                rd[`RMFC_EXC_SCALE_HI:`RMFC_FIELD_LO] = excitationScale;
            end
            // RULE_07: Temperature code passthrough
            `RMFC_ADDR_TEMP: begin
                rd[`RMFC_TEMP_HI:`RMFC_FIELD_LO] = dieTemperature;
            end
            `RMFC_ADDR_VOUT: begin
                rd[`RMFC_VOUT_HI:`RMFC_FIELD_LO] = outputAmplitude;
            end
            `RMFC_ADDR_FAULT: begin
                rd = faultWord;
            end
            `RMFC_ADDR_CTRL: begin
                rd[`RMFC_SEL_HI:`RMFC_SEL_LO] = s_reg.sel;
                rd[`RMFC_GFRZ_BIT] = s_reg.gainFrz;
                rd[`RMFC_OFRZ_BIT] = s_reg.oscFrz;
            end
            `RMFC_ADDR_GAIN_OFFS: begin
                rd[`RMFC_GAIN_HI:`RMFC_GAIN_LO] = s_reg.gain;
                rd[`RMFC_OFFS_HI:`RMFC_OFFS_LO] = s_reg.offs;
            end
            `RMFC_ADDR_DRIVE: begin
                rd[`RMFC_DRV_HI:`RMFC_DRV_LO] = s_reg.drive;
            end
            // RULE_09: Verify status flag
            `RMFC_ADDR_VERIFY: begin
                rd[`RMFC_VERIFY_BIT] = nvmVerifyStatus;
            end
            `RMFC_ADDR_WDOG: begin
                rd[`RMFC_WDOG_HI:`RMFC_FIELD_LO] = watchdogCount;
            end
            default: rd = `RMFC_WORD_ZERO;
        endcase

        if (link.reqValid) begin
            s_next.rspValid = 1'b1;
            if (!crcOk) begin
                // Corrupt frames never touch state; answer flags the error
                s_next.rspFrame = rmfc_seal({1'b0, 1'b1, addr, `RMFC_WORD_ZERO});
            end else begin
                s_next.rspFrame = rmfc_seal({wr, 1'b0, addr, rd});
                if (wr) begin
                    // RULE_15: Gated and read-only writes dropped
                    case (addr)
                        `RMFC_ADDR_CTRL: begin
                            // RULE_01: Readout selection write
                            s_next.sel = wdata[`RMFC_SEL_HI:`RMFC_SEL_LO];
                            s_next.gainFrz = wdata[`RMFC_GFRZ_BIT];
                            s_next.oscFrz = wdata[`RMFC_OFRZ_BIT];
                        end
                        `RMFC_ADDR_GAIN_OFFS: begin
                            // RULE_04: Gain gated by freeze
                            // RULE_05: Offset gated by freeze
                            if (s_reg.gainFrz) begin
                                s_next.gain = wdata[`RMFC_GAIN_HI:`RMFC_GAIN_LO];
                                s_next.offs = wdata[`RMFC_OFFS_HI:`RMFC_OFFS_LO];
                            end
                        end
                        `RMFC_ADDR_DRIVE: begin
                            // RULE_06: Drive gated by freeze
                            if (s_reg.oscFrz) begin
                                s_next.drive = wdata[`RMFC_DRV_HI:`RMFC_DRV_LO];
                            end
                        end
                        default: begin
                            // Read-only and unmapped words keep every field
                            s_next.sel = s_reg.sel;
                        end
                    endcase
                end
            end
        end

        if (sentCalc) begin
            // RULE_13: Seeded four-bit CRC
            // RULE_14: Status nibble not included
            s_next.sentCrc = rmfc_crc4(sentNibbles);
            s_next.sentValid = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_reg.sel <= `RMFC_SEL_RST;
            s_reg.gainFrz <= 1'b0;
            s_reg.oscFrz <= 1'b0;
            s_reg.gain <= `RMFC_GAIN_RST;
            s_reg.offs <= `RMFC_OFFS_RST;
            s_reg.drive <= `RMFC_DRV_RST;
            s_reg.rspValid <= 1'b0;
            s_reg.rspFrame <= `RMFC_FRAME_ZERO;
            s_reg.sentCrc <= `RMFC_NIB_ZERO;
            s_reg.sentValid <= 1'b0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign link.rspValid = s_reg.rspValid;
    assign link.rspFrame = s_reg.rspFrame;
    assign readoutSelect = s_reg.sel;
    assign gainFreeze = s_reg.gainFrz;
    assign oscFreeze = s_reg.oscFrz;
    assign gainOverride = s_reg.gain;
    assign offsetOverride = s_reg.offs;
    assign driveOverride = s_reg.drive;
    assign sentCrc = s_reg.sentCrc;
    assign sentCrcValid = s_reg.sentValid;

endmodule // rmfc_device

// *** rmfc_map.svh ***
// Register offsets, field positions, reset values and checksum constants
`ifndef RMFC_MAP_SVH
`define RMFC_MAP_SVH

// Run-time word addresses
`define RMFC_ADDR_POSITION 6'h00
`define RMFC_ADDR_VREC 6'h01
`define RMFC_ADDR_AMP_A 6'h02
`define RMFC_ADDR_AMP_B 6'h03
`define RMFC_ADDR_EXC_AMP 6'h04
`define RMFC_ADDR_EXC_SCALE 6'h05
`define RMFC_ADDR_TEMP 6'h06
`define RMFC_ADDR_VOUT 6'h07
`define RMFC_ADDR_FAULT 6'h08
`define RMFC_ADDR_CTRL 6'h09
`define RMFC_ADDR_GAIN_OFFS 6'h0a
`define RMFC_ADDR_DRIVE 6'h0b
`define RMFC_ADDR_VERIFY 6'h0c
`define RMFC_ADDR_WDOG 6'h3f

// Field positions
`define RMFC_SEL_HI 1
`define RMFC_SEL_LO 0
`define RMFC_GFRZ_BIT 2
`define RMFC_OFRZ_BIT 3
`define RMFC_GAIN_HI 4
`define RMFC_GAIN_LO 0
`define RMFC_OFFS_HI 14
`define RMFC_OFFS_LO 8
`define RMFC_DRV_HI 7
`define RMFC_DRV_LO 0
`define RMFC_VERIFY_BIT 15
`define RMFC_EXC_AMP_HI 13
`define RMFC_EXC_SCALE_HI 2
`define RMFC_TEMP_HI 11
`define RMFC_VOUT_HI 10
`define RMFC_WDOG_HI 7
`define RMFC_FIELD_LO 0

// Readout selection codes
`define RMFC_SEL_PAIR_21 2'h1
`define RMFC_SEL_PAIR_13 2'h2

// Reset values
`define RMFC_SEL_RST 2'h0
`define RMFC_GAIN_RST 5'h00
`define RMFC_OFFS_RST 7'h00
`define RMFC_DRV_RST 8'h00
`define RMFC_WORD_ZERO 16'h0000
`define RMFC_FRAME_ZERO 32'h0000_0000
`define RMFC_NIB_ZERO 4'h0
`define RMFC_BYTE_ZERO 8'h00

// Link frame layout
`define RMFC_FRM_WR 31
`define RMFC_FRM_ERR 30
`define RMFC_FRM_ADDR_HI 29
`define RMFC_FRM_ADDR_LO 24
`define RMFC_FRM_DATA_HI 23
`define RMFC_FRM_DATA_LO 8
`define RMFC_FRM_CRC_HI 7
`define RMFC_FRM_CRC_LO 0
`define RMFC_FRM_BODY_LO 8

// Checksums
`define RMFC_CRC8_POLY 8'h07
`define RMFC_CRC8_SEED 8'hff
`define RMFC_CRC4_POLY 4'hd
`define RMFC_CRC4_SEED 4'h5

`endif

// *** rmfc_pkg.sv ***
// Types and checksum functions shared by both link ends
`include "rmfc_map.svh"
package rmfc_pkg;

    typedef logic [15:0] rmfc_word_t;
    typedef logic [31:0] rmfc_frame_t;

    typedef enum logic [1:0] {
        RMFC_H_IDLE = 2'b01,
        RMFC_H_WAIT = 2'b10
    } rmfc_hstate_t;

    typedef struct packed {
        logic [1:0] sel;
        logic gainFrz;
        logic oscFrz;
        logic [4:0] gain;
        logic [6:0] offs;
        logic [7:0] drive;
        logic rspValid;
        rmfc_frame_t rspFrame;
        logic [3:0] sentCrc;
        logic sentValid;
    } rmfc_dev_state_t;

    typedef struct packed {
        rmfc_hstate_t st;
        logic reqValid;
        rmfc_frame_t reqFrame;
        logic pendWr;
        logic [5:0] pendAddr;
        logic [1:0] pendSel;
        logic [1:0] selShadow;
        logic resValid;
        rmfc_word_t resData;
        logic resError;
        logic resAmpValid;
    } rmfc_host_state_t;

    // Seed sits ahead of the message and is divided through too; the
    // zero-padded body is shifted in, so the seed is not a plain preload
    function automatic logic [7:0] rmfc_crc8(input logic [23:0] body);
        logic [7:0] r;
        logic [31:0] s;
        r = `RMFC_CRC8_SEED;
        s = {body, `RMFC_BYTE_ZERO};
        for (int i = 31; i >= 0; i--) begin
            if (r[7]) begin
                r = {r[6:0], s[i]} ^ `RMFC_CRC8_POLY;
            end else begin
                r = {r[6:0], s[i]};
            end
        end
        return r;
    endfunction

    function automatic logic [3:0] rmfc_crc4(input logic [23:0] nibbles);
        logic [3:0] r;
        logic [27:0] s;
        r = `RMFC_CRC4_SEED;
        s = {nibbles, `RMFC_NIB_ZERO};
        for (int i = 27; i >= 0; i--) begin
            if (r[3]) begin
                r = {r[2:0], s[i]} ^ `RMFC_CRC4_POLY;
            end else begin
                r = {r[2:0], s[i]};
            end
        end
        return r;
    endfunction

    function automatic rmfc_frame_t rmfc_seal(input logic [23:0] body);
        return {body, rmfc_crc8(body)};
    endfunction

endpackage

// *** rmfc_link_if.sv ***
// Frame link between the host controller and the sensor register bank
`timescale 1ns/1ns
interface rmfc_link_if;
    import rmfc_pkg::*;
    logic reqValid;
    rmfc_frame_t reqFrame;
    logic rspValid;
    rmfc_frame_t rspFrame;

    modport host (output reqValid, output reqFrame, input rspValid, input rspFrame);
    modport device (input reqValid, input reqFrame, output rspValid, output rspFrame);
endinterface

// *** rmfc_host.sv ***
// Controller end: issues sealed register frames and checks the answers
`timescale 1ns/1ns
`include "rmfc_map.svh"
module rmfc_host
    import rmfc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Link
    rmfc_link_if.host link,
    // Command
    input wire logic cmdValid,
    input wire logic cmdWrite,
    input wire logic [5:0] cmdAddr,
    input wire logic [15:0] cmdData,
    output logic cmdReady,
    // Mode seen by the sensor's converter path
    input wire logic directConvMode,
    // Result
    output logic resValid,
    output logic [15:0] resData,
    output logic resError,
    output logic resAmpValid
);

    rmfc_host_state_t s_reg;
    rmfc_host_state_t s_next;

    always_comb begin
        logic crcOk;
        logic isAmp;
        crcOk = (rmfc_crc8(link.rspFrame[`RMFC_FRM_WR:`RMFC_FRM_BODY_LO])
                 == link.rspFrame[`RMFC_FRM_CRC_HI:`RMFC_FRM_CRC_LO]);
        isAmp = (s_reg.pendAddr == `RMFC_ADDR_AMP_A) || (s_reg.pendAddr == `RMFC_ADDR_AMP_B);
        s_next = s_reg;
        s_next.reqValid = 1'b0;
        s_next.resValid = 1'b0;
        case (s_reg.st)
            RMFC_H_IDLE: begin
                if (cmdValid) begin
                    // RULE_11: Checksum in low byte
                    // RULE_12: Seeded polynomial checksum
                    s_next.reqFrame = rmfc_seal({cmdWrite, 1'b0, cmdAddr,
                                                 cmdWrite ? cmdData : `RMFC_WORD_ZERO});
                    s_next.reqValid = 1'b1;
                    s_next.pendWr = cmdWrite;
                    s_next.pendAddr = cmdAddr;
                    s_next.pendSel = cmdData[`RMFC_SEL_HI:`RMFC_SEL_LO];
                    s_next.st = RMFC_H_WAIT;
                end
            end
            RMFC_H_WAIT: begin
                if (link.rspValid) begin
                    s_next.resValid = 1'b1;
                    s_next.resData = link.rspFrame[`RMFC_FRM_DATA_HI:`RMFC_FRM_DATA_LO];
                    s_next.resError = !crcOk || link.rspFrame[`RMFC_FRM_ERR];
                    // RULE_03: Amplitude trust qualifier
                    s_next.resAmpValid = isAmp && (directConvMode
                        || s_reg.selShadow == `RMFC_SEL_PAIR_21
                        || s_reg.selShadow == `RMFC_SEL_PAIR_13);
                    // Shadow follows only writes the sensor accepted
                    if (s_reg.pendWr && crcOk && !link.rspFrame[`RMFC_FRM_ERR]
                        && s_reg.pendAddr == `RMFC_ADDR_CTRL) begin
                        s_next.selShadow = s_reg.pendSel;
                    end
                    s_next.st = RMFC_H_IDLE;
                end
            end
            default: s_next.st = RMFC_H_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_reg.st <= RMFC_H_IDLE;
            s_reg.reqValid <= 1'b0;
            s_reg.reqFrame <= `RMFC_FRAME_ZERO;
            s_reg.pendWr <= 1'b0;
            s_reg.pendAddr <= `RMFC_ADDR_POSITION;
            s_reg.pendSel <= `RMFC_SEL_RST;
            s_reg.selShadow <= `RMFC_SEL_RST;
            s_reg.resValid <= 1'b0;
            s_reg.resData <= `RMFC_WORD_ZERO;
            s_reg.resError <= 1'b0;
            s_reg.resAmpValid <= 1'b0;
        end else begin
            s_reg <= s_next;
        end
    end

    // No timeout: the sensor end always answers one cycle after a request
    assign cmdReady = (s_reg.st == RMFC_H_IDLE);
    assign link.reqValid = s_reg.reqValid;
    assign link.reqFrame = s_reg.reqFrame;
    assign resValid = s_reg.resValid;
    assign resData = s_reg.resData;
    assign resError = s_reg.resError;
    assign resAmpValid = s_reg.resAmpValid;

endmodule // rmfc_host

// *** rmfc_properties.sv ***
// Link checker: answer timing, frame checksums and unused field bits
`timescale 1ns/1ns
module rmfc_properties
    import rmfc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Link
    input wire logic reqValid,
    input wire rmfc_frame_t reqFrame,
    input wire logic rspValid,
    input wire rmfc_frame_t rspFrame
);
    // Seed preloaded, then body and eight zeros shifted through
    function automatic logic [7:0] crc8(input logic [23:0] body);
        logic [7:0] r;
        logic [31:0] s;
        r = 8'hff;
        s = {body, 8'h00};
        for (int i = 31; i >= 0; i--) begin
            r = r[7] ? ({r[6:0], s[i]} ^ 8'h07) : {r[6:0], s[i]};
        end
        return r;
    endfunction

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    logic reqGood;
    logic reqRead;
    assign reqGood = reqFrame[7:0] == crc8(reqFrame[31:8]);
    assign reqRead = reqValid && !reqFrame[31];

    answer_follows_a: assert property (reqValid |=> rspValid)
        else $error("answer missing after request");
    answer_cause_a: assert property (rspValid |-> $past(reqValid))
        else $error("answer without request");
    answer_crc_a: assert property (rspValid |-> rspFrame[7:0] == crc8(rspFrame[31:8]))
        else $error("answer checksum wrong");
    request_crc_a: assert property (reqValid |-> reqGood)
        else $error("request checksum wrong");
    answer_addr_a: assert property (reqValid |=> rspFrame[29:24] == $past(reqFrame[29:24]))
        else $error("answer address differs");
    good_no_error_a: assert property (reqValid && reqGood |=> !rspFrame[30])
        else $error("error flag on good frame");
    request_spacing_a: assert property (reqValid |=> !reqValid [*2])
        else $error("requests too close");
    ctrl_unused_a: assert property (reqRead && reqFrame[29:24] == 6'h09 |=> rspFrame[23:12] == 12'h000)
        else $error("control word spare bits set");
    temp_width_a: assert property (reqRead && reqFrame[29:24] == 6'h06 |=> rspFrame[23:20] == 4'h0)
        else $error("temperature upper bits set");
    verify_unused_a: assert property (reqRead && reqFrame[29:24] == 6'h0c |=> rspFrame[22:8] == 15'h0000)
        else $error("verify word spare bits set");

    cover property (reqValid && reqFrame[31]);
    cover property (reqRead && reqFrame[29:24] == 6'h09);
    cover property (reqRead ##1 rspValid ##3 reqValid);
endmodule // rmfc_properties

// *** test_runtime_memory_and_frame_crc.sv ***
// Testbench: register bank over the host link, gated writes, checksums
`timescale 1ns/1ns
module test_runtime_memory_and_frame_crc;
    import rmfc_pkg::*;
    logic clk, rst, cmdValid, cmdWrite, cmdReady, directConvMode, sentCalc;
    logic resValid, resError, resAmpValid, nvmVerifyStatus, gainFreeze, oscFreeze, sentCrcValid;
    logic [5:0] cmdAddr;
    logic [15:0] cmdData, resData;
    logic [1:0] readoutSelect, sel2;
    logic [4:0] gainOverride;
    logic [6:0] offsetOverride;
    logic [7:0] driveOverride;
    logic [3:0] sentCrc;
    logic [23:0] sentNibbles;
    logic [15:0] positionResult = 16'h1234, receiverVectorAmplitude = 16'h2345;
    logic [15:0] receiverPair32Amplitude = 16'h3232, receiverPair21Amplitude = 16'h2121;
    logic [15:0] receiverPair13Amplitude = 16'h1313, faultWord = 16'hbeef;
    logic [13:0] excitationAmplitude = 14'h3abc;
    logic [2:0] excitationScale = 3'h5;
    // Die at 300 K
    logic [11:0] dieTemperature = 12'h320;
    logic [10:0] outputAmplitude = 11'h5a5;
    logic [7:0] watchdogCount = 8'h9c;
    int errCount = 0;
    int totalChecks = 0;

    rmfc_link_if link();
    rmfc_link_if linkB();
    rmfc_device i_rmfc_device (.clk, .rst, .link(link), .positionResult, .receiverVectorAmplitude,
        .receiverPair32Amplitude, .receiverPair21Amplitude, .receiverPair13Amplitude,
        .excitationAmplitude, .excitationScale, .dieTemperature, .outputAmplitude, .faultWord,
        .nvmVerifyStatus, .watchdogCount, .readoutSelect, .gainFreeze, .oscFreeze, .gainOverride,
        .offsetOverride, .driveOverride, .sentCalc, .sentNibbles, .sentCrc, .sentCrcValid);
    // Second end fed with hand-made frames, including broken ones
    rmfc_device i_rmfc_device_b (.clk, .rst, .link(linkB), .positionResult,
        .receiverVectorAmplitude, .receiverPair32Amplitude, .receiverPair21Amplitude,
        .receiverPair13Amplitude, .excitationAmplitude, .excitationScale, .dieTemperature,
        .outputAmplitude, .faultWord, .nvmVerifyStatus, .watchdogCount, .readoutSelect(sel2),
        .gainFreeze(), .oscFreeze(), .gainOverride(), .offsetOverride(), .driveOverride(),
        .sentCalc, .sentNibbles, .sentCrc(), .sentCrcValid());
    rmfc_host i_rmfc_host (.clk, .rst, .link(link), .cmdValid, .cmdWrite, .cmdAddr, .cmdData,
        .cmdReady, .directConvMode, .resValid, .resData, .resError, .resAmpValid);
    rmfc_properties i_rmfc_properties (.clk, .rst, .reqValid(link.reqValid),
        .reqFrame(link.reqFrame), .rspValid(link.rspValid), .rspFrame(link.rspFrame));

    function automatic logic [3:0] crc4(input logic [23:0] d);
        logic [3:0] r;
        logic [27:0] s;
        r = 4'h5;
        s = {d, 4'h0};
        for (int i = 27; i >= 0; i--) begin
            r = r[3] ? ({r[2:0], s[i]} ^ 4'hd) : {r[2:0], s[i]};
        end
        return r;
    endfunction

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        totalChecks++;
        if (seen !== exp) begin
            errCount++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", totalChecks, errCount);
        if (errCount == 0 && totalChecks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Command is taken at the first edge, result pulses two edges later
    task automatic cmd(input logic wr, input logic [5:0] a, input logic [15:0] d);
        int n;
        n = 0;
        @(negedge clk);
        {cmdWrite, cmdAddr, cmdData, cmdValid} = {wr, a, d, 1'b1};
        @(negedge clk);
        cmdValid = 1'b0;
        check("cmdReady busy", cmdReady, 0);
        while (resValid !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        check("result", n < 20, 1);
        check("resError", resError, 0);
        check("cmdReady idle", cmdReady, 1);
    endtask

    task automatic rd(input logic [5:0] a, input logic [15:0] exp);
        cmd(1'b0, a, 16'h0000);
        check($sformatf("word %0d", a), resData, exp);
    endtask

    task automatic raw(input logic [31:0] f);
        @(negedge clk);
        {linkB.reqFrame, linkB.reqValid} = {f, 1'b1};
        @(negedge clk);
        linkB.reqValid = 1'b0;
        check("answer", linkB.rspValid, 1);
    endtask

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial begin
        #200000;
        errCount++;
        results();
    end

    initial begin
        {cmdValid, cmdWrite, cmdAddr, cmdData, directConvMode, sentCalc} = '0;
        {sentNibbles, linkB.reqValid, linkB.reqFrame, nvmVerifyStatus} = {57'h0, 1'b1};
        rst = 1'b1;
        repeat (6) @(negedge clk);
        rst = 1'b0;
        check("known crc", i_rmfc_properties.crc8(24'h0a_02fe), 8'h88);
        check("known crc pkg", rmfc_crc8(24'h0a_02fe), 8'h88);
        rd(6'h09, 16'h0000);
        rd(6'h0a, 16'h0000);
        rd(6'h0b, 16'h0000);
        $display("test reset values done");
        rd(6'h00, 16'h1234);
        rd(6'h01, 16'h2345);
        rd(6'h04, 16'h3abc);
        rd(6'h05, 16'h0005);
        rd(6'h06, 16'(8 * (300 - 200)));
        rd(6'h07, 16'h05a5);
        rd(6'h08, 16'hbeef);
        rd(6'h0c, 16'h8000);
        rd(6'h3f, 16'h009c);
        cmd(1'b1, 6'h08, 16'h0000);
        rd(6'h08, 16'hbeef);
        rd(6'h20, 16'h0000);
        $display("test read-only words done");
        for (int s = 0; s < 4; s++) begin
            cmd(1'b1, 6'h09, 16'(s));
            check("select", readoutSelect, s);
            rd(6'h02, s == 2 ? 16'h2121 : 16'h3232);
            check("ampValid", resAmpValid, s == 1 || s == 2);
            rd(6'h03, s == 2 ? 16'h1313 : 16'h2121);
        end
        directConvMode = 1'b1;
        rd(6'h02, 16'h3232);
        check("ampValid direct", resAmpValid, 1);
        directConvMode = 1'b0;
        $display("test readout selection done");
        cmd(1'b1, 6'h0a, 16'h7f1f);
        rd(6'h0a, 16'h0000);
        cmd(1'b1, 6'h09, 16'h0004);
        check("gainFreeze", gainFreeze, 1);
        cmd(1'b1, 6'h0a, 16'hffff);
        rd(6'h0a, 16'h7f1f);
        check("gain", gainOverride, 5'h1f);
        check("offset", offsetOverride, 7'h7f);
        cmd(1'b1, 6'h0b, 16'hffab);
        rd(6'h0b, 16'h0000);
        cmd(1'b1, 6'h09, 16'h0008);
        check("oscFreeze", oscFreeze, 1);
        cmd(1'b1, 6'h0b, 16'hffab);
        rd(6'h0b, 16'h00ab);
        check("drive", driveOverride, 8'hab);
        cmd(1'b1, 6'h0a, 16'h0000);
        rd(6'h0a, 16'h7f1f);
        cmd(1'b1, 6'h09, 16'hffff);
        rd(6'h09, 16'h000f);
        $display("test freeze gating done");
        @(negedge clk);
        rst = 1'b1;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        rd(6'h09, 16'h0000);
        rd(6'h0a, 16'h0000);
        rd(6'h0b, 16'h0000);
        $display("test mid-run reset done");
        for (int k = 0; k < 4; k++) begin
            @(negedge clk);
            sentNibbles = 24'(24'h3a_5c71 * k + {24{k[0]}});
            sentCalc = 1'b1;
            @(negedge clk);
            sentCalc = 1'b0;
            check("sentValid", sentCrcValid, 1);
            check("sentCrc", sentCrc, crc4(sentNibbles));
        end
        $display("test sent checksum done");
        raw({24'h89_0003, i_rmfc_properties.crc8(24'h89_0003) ^ 8'h01});
        check("bad frame error", linkB.rspFrame[30], 1);
        check("bad frame data", linkB.rspFrame[23:8], 16'h0000);
        check("bad frame select", sel2, 2'h0);
        raw({24'h89_0002, i_rmfc_properties.crc8(24'h89_0002)});
        check("good frame error", linkB.rspFrame[30], 0);
        check("good frame select", sel2, 2'h2);
        $display("test frame checksum done");
        results();
    end
endmodule // test_runtime_memory_and_frame_crc
